// >>> src/psm_ctrl.sv
// power-saving mode controller: reduced rate, halt, sleep and wake
module psm_ctrl
    import psm_pkg::*;
#(
    parameter int REG_SETTLE_CYCLES = 64,
    parameter int OST_CYCLES = OST_PERIODS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // axi4-lite slave
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // cpu core
    input wire logic sleep_exec,
    input wire logic multicycle_busy,
    input wire logic prefetch_clears_gie,
    input wire logic global_irq_enable,
    input wire logic isr_enter,
    input wire logic isr_return,
    output logic cpu_cycle_en,
    output logic periph_clk_en,
    output logic vector_call,
    output logic sleep_as_nop,
    // interrupt and reset sources
    input wire logic irq_pending,
    input wire logic irq_pending_noclk,
    input wire logic windowed_watchdog_expire,
    input wire logic hard_reset_req,
    output logic watchdog_clear,
    output logic watchdog_reset_out,
    // status flags
    output logic powerdown_flag,
    output logic watchdog_expiry_flag,
    // oscillators, converter, io, regulator
    input wire logic [2:0] osc_request,
    input wire logic [2:0] osc_force,
    input wire logic converter_rc_clock,
    input wire logic [7:0] port_periph_active,
    output logic [2:0] osc_enable,
    output logic converter_abort,
    output logic [7:0] port_hold,
    output logic regulator_low_power
);
    localparam logic [11:0] OST_TOP = 12'(OST_CYCLES);
    localparam logic [11:0] REG_TOP = 12'(REG_SETTLE_CYCLES);

    typedef struct packed {
        psm_state_t st;
        logic [7:0] ctrl;
        logic [1:0] regc;
        logic [7:0] div;
        logic [11:0] wait_cnt;
        logic pd;
        logic to;
        logic aw_ok;
        logic w_ok;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic cpu_en;
        logic vec;
        logic vec_pend;
        logic nop;
        logic wdc;
        logic wdr;
        logic [2:0] osc;
        logic abort;
        logic [7:0] hold;
        logic lpreg;
    } psm_regs_t;

    psm_regs_t cur_ff;
    psm_regs_t nxt_s;

    logic rate_en;
    logic wake;
    logic [31:0] rd_val;

    assign rate_en = cur_ff.ctrl[CTRL_RATE_EN];
    // any enabled interrupt wakes, whatever the global enable
    assign wake = irq_pending | windowed_watchdog_expire;

    // read mux; reserved bits read zero
    always_comb
    begin
        unique case (s_araddr)
            ADDR_CTRL: rd_val = {24'h000000, cur_ff.ctrl};
            ADDR_REG: rd_val = {30'h00000000, cur_ff.regc};
            ADDR_STAT: rd_val = {28'h0000000, cur_ff.st, cur_ff.to, cur_ff.pd};
            default: rd_val = 32'h00000000;
        endcase
    end

    // next-state logic for the whole block
    always_comb
    begin
        nxt_s = cur_ff;
        nxt_s.vec = 1'b0;
        nxt_s.nop = 1'b0;
        nxt_s.wdc = 1'b0;
        nxt_s.wdr = 1'b0;
        nxt_s.abort = 1'b0;

        // bus write: address and data accepted in either order
        nxt_s.awready = 1'b0;
        nxt_s.wready = 1'b0;
        if (s_awvalid && !cur_ff.aw_ok && !cur_ff.awready)
        begin
            nxt_s.awready = 1'b1;
            nxt_s.aw_ok = 1'b1;
            nxt_s.awaddr = s_awaddr;
        end
        if (s_wvalid && !cur_ff.w_ok && !cur_ff.wready)
        begin
            nxt_s.wready = 1'b1;
            nxt_s.w_ok = 1'b1;
            nxt_s.wdata = s_wdata;
            nxt_s.wstrb = s_wstrb;
        end
        if (cur_ff.bvalid && s_bready)
            nxt_s.bvalid = 1'b0;
        if (cur_ff.aw_ok && cur_ff.w_ok && !cur_ff.bvalid)
        begin
            nxt_s.aw_ok = 1'b0;
            nxt_s.w_ok = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = RESP_OKAY;
            if (cur_ff.wstrb[0])
            begin
                unique case (cur_ff.awaddr)
                    // reenter bit writable at any time but an isr_enter cycle, also inside the isr
                    ADDR_CTRL: nxt_s.ctrl = cur_ff.wdata[7:0];
                    ADDR_REG: nxt_s.regc = cur_ff.wdata[1:0];
                    ADDR_STAT: nxt_s.bresp = RESP_OKAY;
                    default: nxt_s.bresp = RESP_SLVERR;
                endcase
            end
        end

        // bus read: accept and answer in the same cycle
        nxt_s.arready = 1'b0;
        if (cur_ff.rvalid && s_rready)
            nxt_s.rvalid = 1'b0;
        if (s_arvalid && !cur_ff.arready && !cur_ff.rvalid)
        begin
            nxt_s.arready = 1'b1;
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = rd_val;
            nxt_s.rresp = (s_araddr == ADDR_CTRL || s_araddr == ADDR_REG ||
                           s_araddr == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
        end

        // isr entry/exit flag handling after software writes, so hardware wins
        if (isr_enter)
        begin
            nxt_s.ctrl[CTRL_REENTER] = rate_en;
            if (cur_ff.ctrl[CTRL_RECOVER])
                nxt_s.ctrl[CTRL_RATE_EN] = 1'b0;
            if (!prefetch_clears_gie)
            begin
                // a busy multicycle instruction defers the fetch, never drops it
                nxt_s.vec = !multicycle_busy;
                nxt_s.vec_pend = multicycle_busy;
            end
        end
        if (cur_ff.vec_pend && !multicycle_busy)
        begin
            nxt_s.vec = 1'b1;
            nxt_s.vec_pend = 1'b0;
        end
        if (isr_enter && prefetch_clears_gie && rate_en)
            nxt_s.ctrl[CTRL_RATE_EN] = 1'b0;
        if (isr_return)
            nxt_s.ctrl[CTRL_RATE_EN] = cur_ff.ctrl[CTRL_REENTER];

        // reduced-rate divider: one cpu cycle per 2^(code+1)
        if (!rate_en || cur_ff.div == psm_ratio_top(cur_ff.ctrl[2:0]))
            nxt_s.div = 8'h00;
        else
            nxt_s.div = cur_ff.div + 8'h01;

        unique case (cur_ff.st)
            PS_RUN:
            begin
                nxt_s.cpu_en = !rate_en || nxt_s.div == 8'h00;
                if (sleep_exec)
                begin
                    if (irq_pending_noclk && !global_irq_enable)
                        nxt_s.nop = 1'b1;
                    else
                    begin
                        nxt_s.wdc = 1'b1;
                        nxt_s.pd = 1'b0;
                        nxt_s.to = 1'b1;
                        nxt_s.cpu_en = 1'b0;
                        if (cur_ff.ctrl[CTRL_HALT_SEL])
                            nxt_s.st = PS_HALT;
                        else
                        begin
                            nxt_s.st = PS_SLEEP;
                            nxt_s.abort = !converter_rc_clock;
                            nxt_s.lpreg = cur_ff.regc[REG_LP_SEL];
                        end
                    end
                end
            end
            PS_SLEEP:
            begin
                nxt_s.cpu_en = 1'b0;
                if (wake)
                begin
                    nxt_s.st = PS_WAIT;
                    nxt_s.wdc = 1'b1;
                    nxt_s.lpreg = 1'b0;
                    // crystal start-up then regulator settle
                    nxt_s.wait_cnt = (cur_ff.regc[REG_CRYSTAL] ? OST_TOP : 12'h000) +
                        (cur_ff.regc[REG_LP_SEL] ? REG_TOP : 12'h000);
                end
            end
            PS_WAIT:
            begin
                if (cur_ff.wait_cnt == 12'h000)
                begin
                    nxt_s.st = PS_RUN;
                    nxt_s.cpu_en = 1'b1;
                    nxt_s.vec = global_irq_enable && irq_pending;
                end
                else
                    nxt_s.wait_cnt = cur_ff.wait_cnt - 12'h001;
            end
            PS_HALT:
            begin
                nxt_s.cpu_en = 1'b0;
                if (irq_pending || windowed_watchdog_expire)
                begin
                    nxt_s.st = PS_RUN;
                    nxt_s.wdc = 1'b1;
                    nxt_s.cpu_en = 1'b1;
                    nxt_s.vec = global_irq_enable && irq_pending;
                end
            end
        endcase

        // watchdog resets only in run, not in halt, sleep or wait; halt and sleep wake instead
        nxt_s.wdr = windowed_watchdog_expire && nxt_s.st == PS_RUN &&
            cur_ff.st == PS_RUN;
        nxt_s.osc = (nxt_s.st == PS_SLEEP) ? (osc_request | osc_force) : 3'b111;
        nxt_s.hold = (nxt_s.st == PS_SLEEP) ? ~port_periph_active : 8'h00;

        // external, brownout and power-on resets leave every mode
        if (hard_reset_req)
        begin
            nxt_s.st = PS_RUN;
            nxt_s.cpu_en = 1'b1;
            nxt_s.ctrl = CTRL_RESET;
            nxt_s.lpreg = 1'b0;
            nxt_s.vec_pend = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cur_ff <= '0;
            cur_ff.pd <= 1'b1;
            cur_ff.to <= 1'b1;
            cur_ff.cpu_en <= 1'b1;
            cur_ff.osc <= 3'b111;
            cur_ff.st <= PS_RUN;
        end
        else
            cur_ff <= nxt_s;
    end

    // outputs straight from flip-flops, except periph_clk_en decoded from the state
    assign s_awready = cur_ff.awready;
    assign s_wready = cur_ff.wready;
    assign s_bvalid = cur_ff.bvalid;
    assign s_bresp = cur_ff.bresp;
    assign s_arready = cur_ff.arready;
    assign s_rvalid = cur_ff.rvalid;
    assign s_rdata = cur_ff.rdata;
    assign s_rresp = cur_ff.rresp;
    assign cpu_cycle_en = cur_ff.cpu_en;
    assign periph_clk_en = cur_ff.st != PS_SLEEP ? 1'b1 : 1'b0;
    assign vector_call = cur_ff.vec;
    assign sleep_as_nop = cur_ff.nop;
    assign watchdog_clear = cur_ff.wdc;
    assign watchdog_reset_out = cur_ff.wdr;
    assign powerdown_flag = cur_ff.pd;
    assign watchdog_expiry_flag = cur_ff.to;
    assign osc_enable = cur_ff.osc;
    assign converter_abort = cur_ff.abort;
    assign port_hold = cur_ff.hold;
    assign regulator_low_power = cur_ff.lpreg;

    // assertions
    chk_sleep_flags: assert property (@(posedge clk) disable iff (srst)
        (cur_ff.st == PS_RUN && sleep_exec && !hard_reset_req &&
         !(irq_pending_noclk && !global_irq_enable)) |=> !powerdown_flag && watchdog_clear)
        else $error("sleep entry flags wrong");
    chk_nop_sleep: assert property (@(posedge clk) disable iff (srst)
        (cur_ff.st == PS_RUN && sleep_exec && irq_pending_noclk && !global_irq_enable)
        |=> sleep_as_nop && !watchdog_clear && $stable(powerdown_flag))
        else $error("nop sleep changed state");
    chk_halt_select: assert property (@(posedge clk) disable iff (srst)
        (cur_ff.st == PS_RUN && sleep_exec && !hard_reset_req && cur_ff.ctrl[7] &&
         !(irq_pending_noclk && !global_irq_enable)) |=> cur_ff.st == PS_HALT)
        else $error("halt not entered");
    chk_roi_clear: assert property (@(posedge clk) disable iff (srst)
        (isr_enter && cur_ff.ctrl[5] && !isr_return && !hard_reset_req) |=> !cur_ff.ctrl[6])
        else $error("recover did not clear rate");
    chk_doe_copy: assert property (@(posedge clk) disable iff (srst)
        (isr_enter && !hard_reset_req) |=> cur_ff.ctrl[4] == $past(cur_ff.ctrl[6]))
        else $error("reenter not copied");
    chk_return_rate: assert property (@(posedge clk) disable iff (srst)
        (isr_return && !hard_reset_req) |=> cur_ff.ctrl[6] == $past(cur_ff.ctrl[4]))
        else $error("return rate wrong");
    chk_halt_wake: assert property (@(posedge clk) disable iff (srst)
        (cur_ff.st == PS_HALT && irq_pending) |=> cur_ff.st == PS_RUN && watchdog_clear)
        else $error("halt not ended");
    chk_no_wd_halt: assert property (@(posedge clk) disable iff (srst)
        (cur_ff.st == PS_HALT) |=> !watchdog_reset_out)
        else $error("watchdog reset in halt");
    chk_sleep_cpu: assert property (@(posedge clk) disable iff (srst)
        (cur_ff.st == PS_SLEEP ##1 cur_ff.st == PS_SLEEP) |-> !cpu_cycle_en)
        else $error("cpu running in sleep");
    chk_hard_reset: assert property (@(posedge clk) disable iff (srst)
        hard_reset_req |=> cpu_cycle_en && cur_ff.ctrl == CTRL_RESET && cur_ff.st == PS_RUN)
        else $error("hard reset did not leave low-power mode");
    chk_vec_wait: assert property (@(posedge clk) disable iff (srst)
        (cur_ff.vec_pend && multicycle_busy && cur_ff.st == PS_RUN) |=> !vector_call)
        else $error("vector fetched during multicycle instruction");
endmodule

// >>> src/psm_pkg.sv
// constants, types and register map of the power-saving mode controller
package psm_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_REG = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;
    // fields of the control and reg registers
    localparam int CTRL_HALT_SEL = 7;
    localparam int CTRL_RATE_EN = 6;
    localparam int CTRL_RECOVER = 5;
    localparam int CTRL_REENTER = 4;
    localparam int CTRL_RATIO_LO = 0;
    localparam int REG_LP_SEL = 1;
    localparam int REG_CRYSTAL = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // oscillator start-up wait in oscillator periods
    localparam int OST_PERIODS = 1024;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // power states, gray along idle->sleep->wake
    typedef enum logic [1:0]
    {
        PS_RUN = 2'b00,
        PS_SLEEP = 2'b01,
        PS_WAIT = 2'b11,
        PS_HALT = 2'b10
    } psm_state_t;

    // divider terminal count for ratio code: 2^(code+1) - 1
    function automatic logic [7:0] psm_ratio_top(input logic [2:0] code);
        logic [8:0] n;
        n = 9'h002 << code;
        return 8'(n - 9'h001);
    endfunction
endpackage

// >>> tb/psm_far_model.sv
// far side model: interrupt flags and watchdog of the core
module psm_far_model
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // bench requests
    input wire logic irq_set,
    input wire logic irq_clr,
    input wire logic windowed_watchdog_set,
    // from the block
    input wire logic watchdog_clear,
    input wire logic watchdog_reset_out,
    // to the block
    output logic irq_pending,
    output logic irq_pending_noclk,
    output logic windowed_watchdog_expire,
    // event counts for the bench
    output int n_clr,
    output int n_rst
);
    timeunit 1ns;
    timeprecision 100ps;
    // flag latches until cleared; expiry is a one-cycle event
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq_pending <= 1'b0;
            windowed_watchdog_expire <= 1'b0;
            n_clr <= 0;
            n_rst <= 0;
        end
        else
        begin
            irq_pending <= irq_set | (irq_pending & ~irq_clr);
            windowed_watchdog_expire <= windowed_watchdog_set;
            n_clr <= n_clr + int'(watchdog_clear);
            n_rst <= n_rst + int'(watchdog_reset_out);
        end
    end
    // no clock-switch source here, so both views agree
    assign irq_pending_noclk = irq_pending;
endmodule

// >>> tb/psm_ctrl_tb.sv
// self-checking bench of the power-saving mode controller
module psm_ctrl_tb
    import psm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0] s_wstrb = 4'hf;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    logic sleep_exec = 1'b0, global_irq_enable = 1'b0, isr_enter = 1'b0, isr_return = 1'b0;
    logic irq_set = 1'b0, irq_clr = 1'b0, windowed_watchdog_set = 1'b0, converter_rc_clock = 1'b0;
    logic multicycle_busy = 1'b0, prefetch_clears_gie = 1'b0, hard_reset_req = 1'b0;
    logic [2:0] osc_request = 3'h0, osc_force = 3'h0, osc_enable;
    logic [7:0] port_periph_active = 8'h00, port_hold;
    logic irq_pending, irq_pending_noclk, windowed_watchdog_expire, watchdog_clear;
    logic watchdog_reset_out, cpu_cycle_en, periph_clk_en, vector_call, sleep_as_nop;
    logic powerdown_flag, watchdog_expiry_flag, converter_abort, regulator_low_power;
    int n_clr, n_rst, error_cnt = 0, n_tests = 0, cyc = 0, n_vc = 0;
    logic [33:0] exp_q[$], msk_q[$];

    // short counts keep the wake waits visible in a brief run
    psm_ctrl #(.REG_SETTLE_CYCLES(4), .OST_CYCLES(4)) u_psm_ctrl
    (
        .clk, .srst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .sleep_exec, .multicycle_busy,
        .prefetch_clears_gie, .global_irq_enable, .isr_enter, .isr_return,
        .cpu_cycle_en, .periph_clk_en, .vector_call, .sleep_as_nop, .irq_pending,
        .irq_pending_noclk, .windowed_watchdog_expire, .hard_reset_req,
        .watchdog_clear, .watchdog_reset_out, .powerdown_flag, .watchdog_expiry_flag,
        .osc_request, .osc_force, .converter_rc_clock, .port_periph_active, .osc_enable,
        .converter_abort, .port_hold, .regulator_low_power
    );
    psm_far_model u_psm_far_model
    (
        .clk, .srst, .irq_set, .irq_clr, .windowed_watchdog_set, .watchdog_clear, .watchdog_reset_out,
        .irq_pending, .irq_pending_noclk, .windowed_watchdog_expire, .n_clr, .n_rst
    );

    always #2 clk = ~clk;

    task end_sim();
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one-cycle pulses of isr events and far-side requests
    task pl(input logic [4:0] v);
        @(posedge clk);
        {isr_enter, isr_return, irq_set, irq_clr, windowed_watchdog_set} <= v;
        @(posedge clk);
        {isr_enter, isr_return, irq_set, irq_clr, windowed_watchdog_set} <= 5'h00;
    endtask

    // address and data offered together, each dropped once taken
    task wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st, input logic [1:0] e);
        @(posedge clk);
        s_awaddr <= a;
        s_wdata <= {24'h0, d};
        s_wstrb <= st;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (s_bvalid !== 1'b1)
        begin
            @(posedge clk);
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
        end
        s_bready <= 1'b0;
        chk(34'(s_bresp), 34'(e));
    endtask

    // the expected answer is noted before the request goes out
    task rd(input logic [11:0] a, input logic [33:0] e, input logic [33:0] m);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        exp_q.push_back(e);
        msk_q.push_back(m);
        do
        begin
            @(posedge clk);
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
        end
        while (s_rvalid !== 1'b1);
        s_rready <= 1'b0;
    endtask

    task slp(input logic rc);
        @(posedge clk);
        sleep_exec <= 1'b1;
        converter_rc_clock <= rc;
        osc_request <= 3'($urandom);
        osc_force <= 3'($urandom);
        port_periph_active <= 8'($urandom);
        @(posedge clk);
        sleep_exec <= 1'b0;
        #1;
    endtask

    // raise a wake source, count cycles until the cpu runs again
    task wake(input logic src, output int n);
        pl({2'b00, src, 1'b0, !src});
        n = 0;
        while (cpu_cycle_en !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        pl(5'h02);
        tk(4);
    endtask

    // oldest note is matched to each read answer as it is accepted
    always @(posedge clk)
    begin
        if (s_rvalid === 1'b1 && s_rready === 1'b1 && exp_q.size() > 0)
        begin
            chk({s_rresp, s_rdata} & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    // vector fetches and hang guard
    always @(posedge clk)
    begin
        n_vc += int'(vector_call === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    initial
    begin
        int k, p, n0, n1, v0;
        void'($urandom(32'h725c));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk(34'({powerdown_flag, watchdog_expiry_flag, cpu_cycle_en, osc_enable}), 34'h3f);
        rd(ADDR_STAT, 34'h3, 34'h3000000ff);
        wr(ADDR_CTRL, 8'hff, 4'h0, RESP_OKAY);
        rd(ADDR_CTRL, 34'h0, 34'h3000000ff);
        wr(12'h00c, 8'h01, 4'h1, RESP_SLVERR);
        rd(12'h00c, {RESP_SLVERR, 32'h0}, 34'h300000000);
        // pending enabled interrupt with global enable clear: sleep is a no-op
        pl(5'h04);
        slp(1'b0);
        chk({sleep_as_nop, powerdown_flag, n_clr}, {2'b11, 32'd0});
        pl(5'h02);
        // one cpu cycle in N for every ratio code, peripherals never stall
        p = 0;
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_CTRL, 8'h40 | 8'(c), 4'h1, RESP_OKAY);
            tk(2 << c);
            k = 0;
            for (int i = 0; i < (4 << c); i++)
            begin
                @(posedge clk);
                k += int'(cpu_cycle_en === 1'b1);
                p += int'(periph_clk_en !== 1'b1);
            end
            chk(34'(k), 34'd2);
        end
        chk(34'(p), 34'd0);
        // service entry and return with both recovery settings
        wr(ADDR_CTRL, 8'h60, 4'h1, RESP_OKAY);
        pl(5'h10);
        rd(ADDR_CTRL, 34'h30, 34'hf0);
        pl(5'h08);
        rd(ADDR_CTRL, 34'h40, 34'h40);
        wr(ADDR_CTRL, 8'h40, 4'h1, RESP_OKAY);
        pl(5'h10);
        rd(ADDR_CTRL, 34'h50, 34'hf0);
        wr(ADDR_CTRL, 8'h40, 4'h1, RESP_OKAY);
        pl(5'h08);
        rd(ADDR_CTRL, 34'h00, 34'h40);
        // vector waits for a multicycle instruction; a prefetch that clears the global enable skips it
        wr(ADDR_CTRL, 8'h60, 4'h1, RESP_OKAY);
        @(posedge clk);
        multicycle_busy <= 1'b1;
        v0 = n_vc;
        pl(5'h10);
        tk(3);
        chk(34'(n_vc - v0), 34'd0);
        @(posedge clk);
        multicycle_busy <= 1'b0;
        tk(3);
        chk(34'(n_vc - v0), 34'd1);
        wr(ADDR_CTRL, 8'h40, 4'h1, RESP_OKAY);
        @(posedge clk);
        prefetch_clears_gie <= 1'b1;
        v0 = n_vc;
        pl(5'h10);
        tk(2);
        prefetch_clears_gie <= 1'b0;
        chk(34'(n_vc - v0), 34'd0);
        rd(ADDR_CTRL, 34'h10, 34'h50);
        // full sleep, crystal and low-power regulator, vectored wake
        wr(ADDR_REG, 8'h03, 4'h1, RESP_OKAY);
        wr(ADDR_CTRL, 8'h00, 4'h1, RESP_OKAY);
        @(posedge clk);
        global_irq_enable <= 1'b1;
        slp(1'b0);
        chk(34'({powerdown_flag, watchdog_expiry_flag, converter_abort, cpu_cycle_en}), 34'h6);
        tk(2);
        chk(34'(periph_clk_en), 34'h0);
        chk(34'({regulator_low_power, osc_enable, port_hold}), 34'({1'b1, osc_request | osc_force, ~port_periph_active}));
        chk(34'(n_clr), 34'd1);
        v0 = n_vc;
        wake(1'b1, n1);
        chk(34'(n_clr), 34'd2);
        chk(34'(n_vc - v0), 34'd1);
        // plain wake: no crystal wait, no regulator delay, inline resume
        wr(ADDR_REG, 8'h00, 4'h1, RESP_OKAY);
        @(posedge clk);
        global_irq_enable <= 1'b0;
        slp(1'b1);
        chk(34'({converter_abort, powerdown_flag}), 34'h0);
        tk(2);
        chk(34'(regulator_low_power), 34'h0);
        v0 = n_vc;
        wake(1'b1, n0);
        chk(34'(n_vc - v0), 34'd0);
        chk(34'(n1 >= n0 + 4), 34'h1);
        // cpu-only halt ended by watchdog, then by interrupt
        wr(ADDR_CTRL, 8'h80, 4'h1, RESP_OKAY);
        for (int s = 0; s < 2; s++)
        begin
            slp(1'b0);
            tk(2);
            chk(34'({periph_clk_en, cpu_cycle_en}), 34'h2);
            wake(s[0], n0);
            chk(34'(n0 < 200), 34'h1);
            rd(ADDR_CTRL, 34'h80, 34'h80);
        end
        chk(34'(n_rst), 34'd0);
        // outside halt the watchdog expiry is a reset
        wr(ADDR_CTRL, 8'h00, 4'h1, RESP_OKAY);
        pl(5'h01);
        tk(6);
        chk(34'(n_rst), 34'd1);
        // pin, brownout or power-on reset leaves sleep and clears control
        wr(ADDR_CTRL, 8'h47, 4'h1, RESP_OKAY);
        slp(1'b0);
        @(posedge clk);
        hard_reset_req <= 1'b1;
        @(posedge clk);
        hard_reset_req <= 1'b0;
        #1;
        chk(34'({cpu_cycle_en, periph_clk_en}), 34'h3);
        rd(ADDR_CTRL, 34'h0, 34'hff);
        end_sim();
    end
endmodule
